// >>> shared/dddu_pkg.sv
// Purpose: shared constants and types of the dual converter update and clear control
// Assumes: 16-bit codes, two channels, 24-bit serial frames
// Notes:   apb offsets are byte addresses of aligned 32-bit words
package dddu_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int DDDU_CHANNELS = 2;
    localparam int DDDU_CODE_W   = 16;
    localparam int DDDU_FRAME_W  = 24;
    localparam logic [4:0] DDDU_FRAME_BITS = 5'h18;
    localparam logic [4:0] DDDU_FRAME_SAT  = 5'h19;
    localparam int DDDU_PIN_N    = 6;
    // ----------------------------------------------------------------
    // apb register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] DDDU_CTRL_OFF   = 8'h00;
    localparam logic [7:0] DDDU_RANGE_OFF  = 8'h04;
    localparam logic [7:0] DDDU_POWER_OFF  = 8'h08;
    localparam logic [7:0] DDDU_CODE0_OFF  = 8'h0c;
    localparam logic [7:0] DDDU_CODE1_OFF  = 8'h10;
    localparam logic [7:0] DDDU_STATUS_OFF = 8'h14;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DDDU_CTRL_CLRSEL_BIT  = 0;
    localparam int DDDU_CTRL_CLRCMD_BIT  = 1;
    localparam int DDDU_STAT_CLR_BIT     = 0;
    localparam int DDDU_STAT_BADFRM_BIT  = 1;
    localparam int DDDU_RANGE_STRIDE     = 4;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] DDDU_RST_CODE  = 16'h0000;
    localparam logic [2:0]  DDDU_RST_RANGE = 3'h0;
    localparam logic        DDDU_RST_POWER = 1'b0;
    localparam logic        DDDU_RST_CTRL  = 1'b0;
    // ----------------------------------------------------------------
    // serial frame decode
    // ----------------------------------------------------------------
    localparam logic [2:0] DDDU_SEL_DAC   = 3'h0;
    localparam logic [2:0] DDDU_SEL_RANGE = 3'h1;
    localparam logic [2:0] DDDU_SEL_POWER = 3'h2;
    localparam logic [2:0] DDDU_SEL_CTRL  = 3'h3;
    localparam logic [2:0] DDDU_ADR_ALL   = 3'h4;
    localparam logic [2:0] DDDU_ADR_CFG   = 3'h1;
    localparam logic [2:0] DDDU_ADR_CLEAR = 3'h4;
    // ----------------------------------------------------------------
    // codes and ranges
    // ----------------------------------------------------------------
    localparam logic [15:0] DDDU_CODE_ZERO = 16'h0000;
    localparam logic [15:0] DDDU_CODE_MID  = 16'h8000;
    localparam logic [2:0]  DDDU_RANGE_BIP = 3'h3;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        rw;
        logic [2:0]  sel;
        logic        pad;
        logic [2:0]  adr;
        logic [15:0] data;
    } dddu_frame_t;

    typedef struct packed {
        logic        powered;
        logic [2:0]  range;
        logic [15:0] code;
    } dddu_chan_t;

    typedef enum logic {DDDU_FRM_IDLE, DDDU_FRM_SHIFT} dddu_frm_state_t;
endpackage

// >>> hdl/dddu_sync.sv
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: pins are asynchronous to pclk
// Notes:   every bit resets high, the idle level of the pins
`timescale 1ns/1ps
`default_nettype none
module dddu_sync import dddu_pkg::*; (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [DDDU_PIN_N-1:0] pin_i,
    output logic      [DDDU_PIN_N-1:0] pin_s
);
    logic [DDDU_PIN_N-1:0] meta_q;
    logic [DDDU_PIN_N-1:0] sync_q;

    genvar b;
    generate
        for (b = 0; b < DDDU_PIN_N; b++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q[b] <= 1'b1;
                    sync_q[b] <= 1'b1;
                end else begin
                    meta_q[b] <= pin_i[b];
                    sync_q[b] <= meta_q[b];
                end
            end
        end
    endgenerate

    assign pin_s = sync_q;
endmodule
`default_nettype wire

// >>> hdl/dddu_frame.sv
// Purpose: serial frame receiver on sampled serial clock and frame sync
// Assumes: inputs already synchronised to pclk
// Notes:   a frame is valid only with exactly 24 falling serial edges
`timescale 1ns/1ps
`default_nettype none
module dddu_frame import dddu_pkg::*; (
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  sclk_s,
    input  wire logic  sync_n_s,
    input  wire logic  sdin_s,
    output logic       frame_done,
    output logic       frame_ok,
    output dddu_frame_t frame
);
    dddu_frm_state_t          state_q;
    logic                     sclk_prev_q;
    logic                     sync_prev_q;
    logic [4:0]               cnt_q;
    logic [DDDU_FRAME_W-1:0]  sr_q;
    logic                     done_q;
    logic                     ok_q;
    logic                     sclk_fall;
    logic                     sync_fall;
    logic                     sync_rise;

    assign sclk_fall = sclk_prev_q & ~sclk_s;
    assign sync_fall = sync_prev_q & ~sync_n_s;
    assign sync_rise = ~sync_prev_q & sync_n_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_q <= 1'b1;
            sync_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            sync_prev_q <= sync_n_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= DDDU_FRM_IDLE;
        end else begin
            unique case (state_q)
                DDDU_FRM_IDLE: if (sync_fall) state_q <= DDDU_FRM_SHIFT;
                DDDU_FRM_SHIFT: if (sync_rise) state_q <= DDDU_FRM_IDLE;
            endcase
        end
    end

    // count falling edges and shift msb first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h00;
            sr_q  <= '0;
        end else if (sync_fall) begin
            cnt_q <= 5'h00;
        end else if (state_q == DDDU_FRM_SHIFT && sclk_fall) begin
            cnt_q <= (cnt_q == DDDU_FRAME_SAT) ? cnt_q : cnt_q + 5'h01;
            sr_q  <= {sr_q[DDDU_FRAME_W-2:0], sdin_s};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            ok_q   <= 1'b0;
        end else begin
            done_q <= (state_q == DDDU_FRM_SHIFT) && sync_rise;
            ok_q   <= (cnt_q == DDDU_FRAME_BITS); // R15
        end
    end

    assign frame_done = done_q;
    assign frame_ok   = ok_q;
    assign frame      = dddu_frame_t'(sr_q);
endmodule
`default_nettype wire

// >>> hdl/dddu_ctrl.sv
// Purpose: update, clear, power and coding control of a dual voltage converter
// Assumes: pin inputs asynchronous; apb on pclk; converter takes offset-binary codes
// Notes:   apb answers with one wait state; writes and serial frames share registers
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: load strobe low through a frame: addressed channel updates at frame end
// R2: load strobe high through a frame: hold, then update all on strobe fall
// R3: clear pin low forces outputs to zero-scale or midscale by clear select bit
// R4: after clear release outputs keep cleared value until reprogrammed
// R5: no output update of any kind while clear pin is low
// R6: clear command in control register performs the same clear
// R7: reset loads every register with zero, all channels powered down
// R8: reset range of every channel is the 5 V unipolar range
// R9: data writes to a powered-down channel are discarded
// R10: host sets ranges, then powers channels, then writes codes
// R11: unipolar ranges use straight binary codes
// R12: bipolar ranges use offset binary or twos complement per coding pin
// R13: offset binary: 8000 is zero, ffff positive, 0000 negative extreme
// R14: twos complement: 0000 is zero, 7fff positive, 8000 negative extreme
// R15: frames without exactly 24 falling serial edges are invalid
// R16: twos complement converts to offset binary by inverting the msb
module dddu_ctrl import dddu_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        sync_n,
    input  wire logic        sdin,
    input  wire logic        load_update_strobe_n,
    input  wire logic        clear_outputs_n,
    input  wire logic        bipolar_coding_select,
    output dddu_chan_t [DDDU_CHANNELS-1:0] dac_o
);
    // ----------------------------------------------------------------
    // pin synchronisers and frame receiver
    // ----------------------------------------------------------------
    logic [DDDU_PIN_N-1:0] pins_s;
    logic                  sclk_s;
    logic                  sync_n_s;
    logic                  sdin_s;
    logic                  load_update_strobe_n_n_s;
    logic                  clr_n_s;
    logic                  bin_s;
    logic                  frame_done;
    logic                  frame_ok;
    dddu_frame_t           frame;

    dddu_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   ({bipolar_coding_select, clear_outputs_n, load_update_strobe_n,
                   sdin, sync_n, sclk}),
        .pin_s   (pins_s)
    );

    assign {bin_s, clr_n_s, load_update_strobe_n_n_s, sdin_s, sync_n_s, sclk_s} = pins_s;

    dddu_frame u_frame (
        .pclk       (pclk),
        .presetn    (presetn),
        .sclk_s     (sclk_s),
        .sync_n_s   (sync_n_s),
        .sdin_s     (sdin_s),
        .frame_done (frame_done),
        .frame_ok   (frame_ok),
        .frame      (frame)
    );

    // ----------------------------------------------------------------
    // code conversion
    // ----------------------------------------------------------------
    function automatic logic [15:0] to_dac(input logic [15:0] code,
                                           input logic [2:0]  range,
                                           input logic        offs_bin);
        logic bip;
        bip = (range >= DDDU_RANGE_BIP);
        if (bip && !offs_bin) begin
            to_dac = {~code[15], code[14:0]}; // R12 R14 R16
        end else begin
            to_dac = code; // R11 R13
        end
    endfunction

    function automatic logic [15:0] clr_code(input logic [2:0] range,
                                             input logic       mid);
        logic bip;
        bip = (range >= DDDU_RANGE_BIP);
        clr_code = (bip ^ mid) ? DDDU_CODE_MID : DDDU_CODE_ZERO; // R3
    endfunction

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic        hit_d;
    logic        apb_wr;
    logic        apb_rd_phase;
    logic        clrsel_q;
    logic        clr_cmd_q;
    logic        badfrm_q;
    logic        clear_now;
    logic [1:0][15:0] act_w;
    logic [1:0][15:0] in_w;
    logic [1:0][15:0] wr_code_w;
    logic [1:0][15:0] clr_w;
    logic [1:0][2:0]  range_w;
    logic [1:0]       power_w;
    logic [1:0]       dac_wr;

    assign apb_rd_phase = psel && penable && !pready_q;
    assign apb_wr       = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        unique case (paddr)
            DDDU_CTRL_OFF: rdata_d[DDDU_CTRL_CLRSEL_BIT] = clrsel_q;
            DDDU_RANGE_OFF: begin
                rdata_d[2:0] = range_w[0];
                rdata_d[DDDU_RANGE_STRIDE +: 3] = range_w[1];
            end
            DDDU_POWER_OFF: rdata_d[1:0] = power_w;
            DDDU_CODE0_OFF: rdata_d[15:0] = act_w[0];
            DDDU_CODE1_OFF: rdata_d[15:0] = act_w[1];
            DDDU_STATUS_OFF: begin
                rdata_d[DDDU_STAT_CLR_BIT]    = ~clr_n_s;
                rdata_d[DDDU_STAT_BADFRM_BIT] = badfrm_q;
            end
            default: hit_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= apb_rd_phase;
            pslverr_q <= apb_rd_phase && !hit_d;
            if (apb_rd_phase) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ----------------------------------------------------------------
    // control, clear command and frame status
    // ----------------------------------------------------------------
    logic ser_ok;
    logic ser_ctrl;

    assign ser_ok   = frame_done && frame_ok && !frame.rw;
    assign ser_ctrl = ser_ok && frame.sel == DDDU_SEL_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clrsel_q <= DDDU_RST_CTRL; // R7
        end else if (ser_ctrl && frame.adr == DDDU_ADR_CFG) begin
            clrsel_q <= frame.data[DDDU_CTRL_CLRSEL_BIT];
        end else if (apb_wr && paddr == DDDU_CTRL_OFF) begin
            clrsel_q <= pwdata[DDDU_CTRL_CLRSEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_cmd_q <= 1'b0;
        end else begin
            clr_cmd_q <= (ser_ctrl && frame.adr == DDDU_ADR_CLEAR) ||
                         (apb_wr && paddr == DDDU_CTRL_OFF && pwdata[DDDU_CTRL_CLRCMD_BIT]); // R6
        end
    end

    // sticky invalid-frame flag, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            badfrm_q <= 1'b0;
        end else if (frame_done && !frame_ok) begin
            badfrm_q <= 1'b1; // R15
        end else if (apb_wr && paddr == DDDU_STATUS_OFF && pwdata[DDDU_STAT_BADFRM_BIT]) begin
            badfrm_q <= 1'b0;
        end
    end

    assign clear_now = !clr_n_s || clr_cmd_q;

    // ----------------------------------------------------------------
    // update mode tracking
    // ----------------------------------------------------------------
    logic sync_prev_q;
    logic load_update_strobe_n_prev_q;
    logic hi_seen_q;
    logic load_update_strobe_n_fall;

    assign load_update_strobe_n_fall = load_update_strobe_n_prev_q && !load_update_strobe_n_n_s && sync_n_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev_q <= 1'b1;
            load_update_strobe_n_prev_q <= 1'b1;
            hi_seen_q   <= 1'b0;
        end else begin
            sync_prev_q <= sync_n_s;
            load_update_strobe_n_prev_q <= load_update_strobe_n_n_s;
            if (sync_prev_q && !sync_n_s) begin
                hi_seen_q <= load_update_strobe_n_n_s;
            end else if (!sync_n_s && load_update_strobe_n_n_s) begin
                hi_seen_q <= 1'b1; // R2
            end
        end
    end

    // ----------------------------------------------------------------
    // per-channel registers
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < DDDU_CHANNELS; ch++) begin : g_ch
            logic [15:0] in_q;
            logic [15:0] act_q;
            logic [2:0]  range_q;
            logic        power_q;
            logic        addr_hit;

            assign addr_hit = frame.adr == DDDU_ADR_ALL || frame.adr == 3'(ch * 2);
            assign dac_wr[ch] = ser_ok && frame.sel == DDDU_SEL_DAC && addr_hit
                                && power_q; // R9
            assign wr_code_w[ch] = to_dac(frame.data, range_q, bin_s);
            assign clr_w[ch] = clr_code(range_q, clrsel_q);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    range_q <= DDDU_RST_RANGE; // R7 R8
                end else if (ser_ok && frame.sel == DDDU_SEL_RANGE && addr_hit) begin
                    range_q <= frame.data[2:0];
                end else if (apb_wr && paddr == DDDU_RANGE_OFF) begin
                    range_q <= pwdata[ch * DDDU_RANGE_STRIDE +: 3];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    power_q <= DDDU_RST_POWER; // R7
                end else if (ser_ok && frame.sel == DDDU_SEL_POWER) begin
                    power_q <= frame.data[ch];
                end else if (apb_wr && paddr == DDDU_POWER_OFF) begin
                    power_q <= pwdata[ch];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    in_q <= DDDU_RST_CODE; // R7
                end else if (clear_now) begin
                    in_q <= clr_w[ch]; // R3 R6
                end else if (dac_wr[ch]) begin
                    in_q <= wr_code_w[ch];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    act_q <= DDDU_RST_CODE; // R7
                end else if (clear_now) begin
                    act_q <= clr_w[ch]; // R3 R5 R6
                end else if (dac_wr[ch] && !hi_seen_q) begin
                    act_q <= wr_code_w[ch]; // R1
                end else if (load_update_strobe_n_fall) begin
                    act_q <= in_q; // R2 R4
                end
            end

            assign act_w[ch]   = act_q;
            assign in_w[ch]    = in_q;
            assign range_w[ch] = range_q;
            assign power_w[ch] = power_q;
            assign dac_o[ch]   = '{powered: power_q, range: range_q, code: act_q};
        end
    endgenerate

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    indiv_update_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
        dac_wr[0] && !hi_seen_q && !clear_now |=> act_w[0] == $past(wr_code_w[0]))
        else $error("individual update did not load channel 0");
    simul_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
        dac_wr[1] && hi_seen_q && !clear_now && !load_update_strobe_n_fall |=> $stable(act_w[1]))
        else $error("output changed before load strobe");
    simul_update_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
        load_update_strobe_n_fall && !clear_now && dac_wr == 2'b00 |=> act_w == $past(in_w))
        else $error("load strobe fall did not update all channels");
    clear_force_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
        !clr_n_s ##1 !clr_n_s |-> act_w[0] == $past(clr_w[0]) && in_w[0] == $past(clr_w[0]))
        else $error("clear pin did not force clear code");
    hold_value_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
        !clear_now && !dac_wr[0] && !load_update_strobe_n_fall |=> act_w[0] == $past(act_w[0]))
        else $error("output moved without a programming event");
    clear_block_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        !clr_n_s && (load_update_strobe_n_fall || dac_wr[1]) |=> act_w[1] == $past(clr_w[1]))
        else $error("update passed while clear held");
    cmd_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
        apb_wr && paddr == DDDU_CTRL_OFF && pwdata[DDDU_CTRL_CLRCMD_BIT]
        |=> ##1 act_w[1] == $past(clr_w[1]))
        else $error("clear command had no effect");
    pd_discard_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
        ser_ok && frame.sel == DDDU_SEL_DAC && !power_w[0] && !clear_now
        |=> $stable(in_w[0]))
        else $error("write to powered-down channel was taken");
    twos_msb_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        dac_wr[0] && !hi_seen_q && !clear_now && !bin_s && range_w[0] >= DDDU_RANGE_BIP
        |=> act_w[0] == {~$past(frame.data[15]), $past(frame.data[14:0])})
        else $error("twos complement code not converted");
    unipolar_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        dac_wr[0] && !hi_seen_q && !clear_now && range_w[0] < DDDU_RANGE_BIP
        |=> act_w[0] == $past(frame.data))
        else $error("unipolar code altered");

    indiv_c: cover property (@(posedge pclk) disable iff (!presetn)
        dac_wr[0] && !hi_seen_q && !clear_now);
    simul_c: cover property (@(posedge pclk) disable iff (!presetn)
        dac_wr[1] && hi_seen_q ##[1:200] load_update_strobe_n_fall);
    clear_c: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(clr_n_s) ##[1:400] $rose(clr_n_s));
    badfrm_c: cover property (@(posedge pclk) disable iff (!presetn)
        frame_done && !frame_ok);
endmodule
`default_nettype wire

// >>> dv/dddu_host.sv
// Purpose: host serial controller model driving frames into the control block
// Assumes: sclk period of 8 pclk, 4 pclk per half
// Notes:   sclk idles high; sdin shows the inverted last bit between frames
`timescale 1ns/1ps
`default_nettype none
module dddu_host (
    input  wire logic pclk,
    output logic      sclk,
    output logic      sync_n,
    output logic      sdin
);
    // ----------------------------------------------------------------
    // frame sender
    // ----------------------------------------------------------------
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    task automatic send(input logic [23:0] f, input int n);
        int i;
        sync_n <= 1'b0;
        for (i = 0; i < n; i++) begin
            sdin <= f[23 - (i % 24)];
            repeat (4) @(posedge pclk);
            sclk <= 1'b0;
            repeat (4) @(posedge pclk);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge pclk);
        sync_n <= 1'b1;
        sdin <= ~sdin;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench of the converter update and clear control
// Assumes: apb master and host model on pclk
// Notes:   expected codes follow from the coding rules
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb import dddu_pkg::*; ();
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sclk, sync_n, sdin;
    logic        load_update_strobe_n, clear_outputs_n, bipolar_coding_select;
    logic [15:0] cin [5] = '{16'h7fff, 16'h0000, 16'h8000, 16'h8000, 16'hffff};
    logic [15:0] cexp [5] = '{16'hffff, 16'h8000, 16'h0000, 16'h8000, 16'hffff};
    dddu_chan_t [DDDU_CHANNELS-1:0] dac_o;
    int          errors = 0, total_checks = 0, cyc = 0;
    dddu_ctrl dddu_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sclk, .sync_n, .sdin, .load_update_strobe_n,
        .clear_outputs_n, .bipolar_coding_select, .dac_o);
    dddu_host dddu_host_i (.pclk, .sclk, .sync_n, .sdin);
    // ----------------------------------------------------------------
    // clock, timeout and access tasks
    // ----------------------------------------------------------------
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input logic [23:0] f);
        dddu_host_i.send(f, 24);
        repeat (8) @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0;
        load_update_strobe_n = 1'b0; clear_outputs_n = 1'b1; bipolar_coding_select = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("dac reset", 40'h0, dac_o)
        apb(1'b0, DDDU_RANGE_OFF, 32'h0);
        `CHK("range reset", 32'h0, rd)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        frame(24'h001234);
        `CHK("powered down", 16'h0000, dac_o[0].code)
        apb(1'b1, DDDU_RANGE_OFF, 32'h0);
        apb(1'b1, DDDU_POWER_OFF, 32'h3);
        frame(24'h001234);
        `CHK("ch0 single", 16'h1234, dac_o[0].code)
        `CHK("ch1 held", 16'h0000, dac_o[1].code)
        load_update_strobe_n <= 1'b1;
        frame(24'h02ffff);
        `CHK("ch1 wait", 16'h0000, dac_o[1].code)
        load_update_strobe_n <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("ch1 all", 16'hffff, dac_o[1].code)
        apb(1'b1, DDDU_RANGE_OFF, 32'h3);
        for (int i = 0; i < 5; i++) begin
            bipolar_coding_select <= (i > 2);
            frame({8'h00, cin[i]});
            `CHK("bipolar", cexp[i], dac_o[0].code)
        end
        dddu_host_i.send(24'h00abcd, 23);
        repeat (8) @(posedge pclk);
        `CHK("short frame", 16'hffff, dac_o[0].code)
        apb(1'b0, DDDU_STATUS_OFF, 32'h0);
        `CHK("bad frame flag", 1'b1, rd[DDDU_STAT_BADFRM_BIT])
        apb(1'b1, DDDU_STATUS_OFF, 32'h2);
        apb(1'b0, DDDU_STATUS_OFF, 32'h0);
        `CHK("flag cleared", 1'b0, rd[DDDU_STAT_BADFRM_BIT])
        dddu_host_i.send(24'h00abcd, 25);
        repeat (8) @(posedge pclk);
        `CHK("long frame", 16'hffff, dac_o[0].code)
        apb(1'b0, DDDU_STATUS_OFF, 32'h0);
        `CHK("long flag", 1'b1, rd[DDDU_STAT_BADFRM_BIT])
        clear_outputs_n <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK("clear ch0", 16'h8000, dac_o[0].code)
        `CHK("clear ch1", 16'h0000, dac_o[1].code)
        frame(24'h041111);
        `CHK("blocked", 16'h8000, dac_o[0].code)
        `CHK("blocked ch1", 16'h0000, dac_o[1].code)
        clear_outputs_n <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("kept", 16'h8000, dac_o[0].code)
        apb(1'b1, DDDU_CTRL_OFF, 32'h3);
        repeat (4) @(posedge pclk);
        `CHK("cmd ch0", 16'h0000, dac_o[0].code)
        `CHK("cmd ch1", 16'h8000, dac_o[1].code)
        frame(24'h310000);
        frame(24'h340000);
        `CHK("ser clr ch0", 16'h8000, dac_o[0].code)
        apb(1'b0, DDDU_CODE1_OFF, 32'h0);
        `CHK("ser clr ch1", 32'h0, rd)
        frame(24'h200001);
        apb(1'b0, DDDU_POWER_OFF, 32'h0);
        `CHK("power ch0 only", 32'h1, rd)
        frame(24'h024321);
        `CHK("ch1 discarded", 16'h0000, dac_o[1].code)
        stop_test();
    end
endmodule
`default_nettype wire
